// ==== common/ssbq_pkg.sv ====
// Shared constants and types for the serial slave link with bus quirks
package ssbq_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [7:0] ssbq_byte_t;
	typedef logic [6:0] ssbq_addr_t;
	typedef logic [3:0] ssbq_len_t;
	typedef enum {H_IDLE, H_START, H_LOAD, H_BIT, H_STOP} ssbq_hstate_e;

	// ----------------------------------------------------------------
	// Framing
	// ----------------------------------------------------------------
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] SPI_LAST = 4'h7;
	localparam logic [3:0] I2C_LAST_CNT = 4'h7;
	localparam logic [2:0] SPI_CNT_LAST = 3'h7;
	localparam ssbq_len_t LEN_ONE = 4'h1;
	localparam ssbq_byte_t FILL_BYTE = 8'hFF;

	// Arbitrary slave address and power-up reset opcode
	localparam ssbq_addr_t DEV_ADDR = 7'h2A;
	localparam ssbq_byte_t POR_CMD = 8'hF0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 20;
	localparam int BIT_NS = 10000;
	localparam int QUARTER_CYC = BIT_NS / (4 * CLK_NS);

	// ----------------------------------------------------------------
	// Buffering
	// ----------------------------------------------------------------
	localparam int FIFO_DEPTH = 8;

endpackage

// ==== common/ssbq_if.sv ====
// Two-wire and four-wire link between controller and sensor slave
`timescale 1ns/10ps
`default_nettype none

interface ssbq_if;
	logic scl;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic sda;
	logic sclk;
	logic slave_select_n;
	logic mosi;
	logic miso;

	// Open-drain data line with pull-up
	assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

	modport host (
		output scl,
		output sda_host_o,
		output sda_host_oe,
		output sclk,
		output slave_select_n,
		output mosi,
		input sda,
		input miso
	);

	modport dev (
		input scl,
		input sda,
		input sclk,
		input slave_select_n,
		input mosi,
		output sda_dev_o,
		output sda_dev_oe,
		output miso
	);
endinterface

`default_nettype wire

// ==== src/ssbq_host.sv ====
// Controller end: write FIFO and two-wire / four-wire master
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------------
module ssbq_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;

	assign in_ready = cnt_reg != (AW+1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data = mem_reg[rp_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_reg[wp_reg] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule // ssbq_fifo

// ------------------------------------------------------------------
// Link master
// ------------------------------------------------------------------
module ssbq_host #(
	parameter int QUARTER = ssbq_pkg::QUARTER_CYC,
	parameter int DEPTH = ssbq_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic reset,
	ssbq_if.host bus,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire ssbq_pkg::ssbq_byte_t wr_data,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_spi,
	input wire logic cmd_read,
	input wire logic cmd_por,
	input wire ssbq_pkg::ssbq_addr_t cmd_addr,
	input wire ssbq_pkg::ssbq_len_t cmd_len,
	output logic rd_valid,
	output var ssbq_pkg::ssbq_byte_t rd_data,
	output logic busy
);
	import ssbq_pkg::*;

	ssbq_hstate_e state_reg;
	logic [1:0] q_reg;
	logic [15:0] qt_reg;
	logic tick;
	logic spi_reg;
	logic read_reg;
	logic por_reg;
	logic addr_ph_reg;
	ssbq_addr_t addr_reg;
	ssbq_len_t left_reg;
	ssbq_byte_t tx_reg;
	ssbq_byte_t rx_reg;
	logic [3:0] bit_reg;
	logic scl_reg;
	logic oe_reg;
	logic sclk_reg;
	logic ssn_reg;
	logic mosi_reg;
	logic sda_s1;
	logic sda_s2;
	logic miso_s1;
	logic miso_s2;
	logic in_bit;
	logic last_bit;
	logic need_fifo;
	logic f_valid;
	logic f_ready;
	ssbq_byte_t f_data;

	ssbq_fifo #(
		.WIDTH(BYTE_BITS),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	// ----------------------------------------------------------------
	// Pins and handshakes
	// ----------------------------------------------------------------
	// Clock is only driven, never read back: no arbitration
	assign bus.scl = scl_reg;
	assign bus.sda_host_o = 1'b0;
	assign bus.sda_host_oe = oe_reg;
	assign bus.sclk = sclk_reg;
	assign bus.slave_select_n = ssn_reg;
	assign bus.mosi = mosi_reg;

	assign cmd_ready = state_reg == H_IDLE;
	assign busy = state_reg != H_IDLE;
	assign need_fifo = !por_reg && (spi_reg || (!addr_ph_reg && !read_reg));
	assign f_ready = (state_reg == H_LOAD) && need_fifo;
	assign tick = (state_reg != H_IDLE) && (state_reg != H_LOAD) &&
		(qt_reg == 16'(QUARTER - 1));
	// Data-out line is accepted only while selected
	assign in_bit = spi_reg ? (miso_s2 && !ssn_reg) : sda_s2;
	assign last_bit = bit_reg == (spi_reg ? SPI_LAST : ACK_SLOT);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			miso_s1 <= 1'b1;
			miso_s2 <= 1'b1;
		end else begin
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
			miso_s1 <= bus.miso;
			miso_s2 <= miso_s1;
		end
	end

	// ----------------------------------------------------------------
	// Quarter-bit divider
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset || tick || state_reg == H_IDLE || state_reg == H_LOAD) begin
			qt_reg <= 16'h0000;
		end else begin
			qt_reg <= qt_reg + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg <= H_IDLE;
			q_reg <= 2'h0;
			spi_reg <= 1'b0;
			read_reg <= 1'b0;
			por_reg <= 1'b0;
			addr_ph_reg <= 1'b0;
			addr_reg <= '0;
			left_reg <= '0;
			tx_reg <= FILL_BYTE;
			rx_reg <= '0;
			bit_reg <= 4'h0;
			scl_reg <= 1'b1;
			oe_reg <= 1'b0;
			sclk_reg <= 1'b0;
			ssn_reg <= 1'b1;
			mosi_reg <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= '0;
		end else begin
			rd_valid <= 1'b0;
			case (state_reg)
				H_IDLE: begin
					if (cmd_valid) begin
						spi_reg <= cmd_spi;
						read_reg <= cmd_read && !cmd_por;
						por_reg <= cmd_por;
						addr_ph_reg <= !cmd_spi;
						addr_reg <= cmd_addr;
						left_reg <= cmd_por ? LEN_ONE : cmd_len;
						q_reg <= 2'h0;
						state_reg <= H_START;
					end
				end
				H_START: begin
					if (tick) begin
						q_reg <= q_reg + 2'h1;
						if (q_reg == 2'h0) begin
							if (spi_reg) begin
								ssn_reg <= 1'b0;
							end else begin
								oe_reg <= 1'b1;
							end
						end else begin
							if (!spi_reg) begin
								scl_reg <= 1'b0;
							end
							state_reg <= H_LOAD;
						end
					end
				end
				H_LOAD: begin
					bit_reg <= 4'h0;
					q_reg <= 2'h0;
					if (addr_ph_reg) begin
						tx_reg <= {addr_reg, read_reg};
						state_reg <= H_BIT;
					end else if (por_reg) begin
						tx_reg <= POR_CMD;
						state_reg <= H_BIT;
					end else if (!need_fifo) begin
						tx_reg <= FILL_BYTE;
						state_reg <= H_BIT;
					end else if (f_valid) begin
						tx_reg <= f_data;
						state_reg <= H_BIT;
					end
				end
				H_BIT: begin
					if (tick) begin
						q_reg <= q_reg + 2'h1;
						case (q_reg)
							2'h0: begin
								if (!spi_reg && bit_reg == ACK_SLOT) begin
									// Own acknowledge on reads only
									oe_reg <= read_reg && !addr_ph_reg;
								end else if (spi_reg) begin
									mosi_reg <= tx_reg[7];
								end else begin
									oe_reg <= !tx_reg[7];
								end
							end
							2'h1: begin
								if (spi_reg) begin
									sclk_reg <= 1'b1;
								end else begin
									scl_reg <= 1'b1;
								end
							end
							2'h2: begin
								// Acknowledge slot is never examined
								if (bit_reg != ACK_SLOT) begin
									rx_reg <= {rx_reg[6:0], in_bit};
								end
								tx_reg <= {tx_reg[6:0], 1'b0};
							end
							default: begin
								if (spi_reg) begin
									sclk_reg <= 1'b0;
								end else begin
									scl_reg <= 1'b0;
								end
								bit_reg <= bit_reg + 4'h1;
								if (last_bit) begin
									addr_ph_reg <= 1'b0;
									if (!addr_ph_reg && read_reg) begin
										rd_valid <= 1'b1;
										rd_data <= rx_reg;
									end
									if (!addr_ph_reg) begin
										left_reg <= left_reg - 4'h1;
									end
									// Length alone ends the transfer
									if (!addr_ph_reg && left_reg == LEN_ONE) begin
										state_reg <= H_STOP;
									end else begin
										state_reg <= H_LOAD;
									end
								end
							end
						endcase
					end
				end
				H_STOP: begin
					if (tick) begin
						q_reg <= q_reg + 2'h1;
						case (q_reg)
							2'h0: begin
								if (spi_reg) begin
									ssn_reg <= 1'b1;
								end else begin
									oe_reg <= 1'b1;
								end
							end
							2'h1: begin
								scl_reg <= 1'b1;
							end
							2'h2: begin
								oe_reg <= 1'b0;
							end
							default: begin
								state_reg <= H_IDLE;
							end
						endcase
					end
				end
				default: begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end
endmodule // ssbq_host

`default_nettype wire

// ==== src/ssbq_device.sv ====
// Sensor slave end: two-wire and four-wire serial slave with bus quirks
`timescale 1ns/10ps
`default_nettype none

module ssbq_device #(
	parameter ssbq_pkg::ssbq_addr_t OWN_ADDR = ssbq_pkg::DEV_ADDR
) (
	input wire logic reset,
	ssbq_if.dev bus,
	input wire ssbq_pkg::ssbq_byte_t tx_data,
	output logic i2c_rx_valid,
	output var ssbq_pkg::ssbq_byte_t i2c_rx_data,
	output logic i2c_por,
	output logic spi_rx_valid,
	output var ssbq_pkg::ssbq_byte_t spi_rx_data,
	output logic spi_por
);
	import ssbq_pkg::*;

	logic start_tog_reg;
	logic start_seen_reg;
	logic start_pend;
	logic [3:0] cnt_reg;
	ssbq_byte_t sh_reg;
	ssbq_byte_t rx_byte;
	logic first_reg;
	logic match_reg;
	logic rw_reg;
	logic halt_reg;
	logic own_rd;
	ssbq_byte_t txs_reg;
	logic oe_reg;
	logic [2:0] scnt_reg;
	ssbq_byte_t ssh_reg;
	ssbq_byte_t srx_byte;
	ssbq_byte_t stx_reg;
	logic miso_reg;

	assign start_pend = start_tog_reg != start_seen_reg;
	assign own_rd = match_reg && rw_reg && !first_reg;
	assign rx_byte = {sh_reg[6:0], bus.sda};
	assign srx_byte = {ssh_reg[6:0], bus.mosi};
	assign bus.sda_dev_o = 1'b0;
	assign bus.sda_dev_oe = oe_reg;
	// No high-impedance state on the data-out pin
	assign bus.miso = miso_reg;

	// ----------------------------------------------------------------
	// Start detection: data falls while clock high
	// ----------------------------------------------------------------
	// Link clocks stand still, so link flops reset without an edge
	always_ff @(negedge bus.sda or posedge reset) begin
		if (reset) begin
			start_tog_reg <= 1'b0;
		end else if (bus.scl) begin
			start_tog_reg <= !start_tog_reg;
		end
	end

	// ----------------------------------------------------------------
	// Two-wire receive on rising clock
	// ----------------------------------------------------------------
	always_ff @(posedge bus.scl or posedge reset) begin
		if (reset) begin
			start_seen_reg <= 1'b0;
			cnt_reg <= 4'h0;
			sh_reg <= '0;
			first_reg <= 1'b0;
			match_reg <= 1'b0;
			rw_reg <= 1'b0;
			halt_reg <= 1'b0;
			i2c_rx_valid <= 1'b0;
			i2c_rx_data <= '0;
			i2c_por <= 1'b0;
		end else begin
			i2c_rx_valid <= 1'b0;
			i2c_por <= 1'b0;
			if (start_pend) begin
				start_seen_reg <= start_tog_reg;
				sh_reg <= {sh_reg[6:0], bus.sda};
				cnt_reg <= 4'h1;
				first_reg <= 1'b1;
				halt_reg <= 1'b0;
			end else if (cnt_reg == ACK_SLOT) begin
				cnt_reg <= 4'h0;
				first_reg <= 1'b0;
				// Any low seen here ends active sending
				if (own_rd && !bus.sda) begin
					halt_reg <= 1'b1;
				end
			end else begin
				sh_reg <= rx_byte;
				cnt_reg <= cnt_reg + 4'h1;
				if (cnt_reg == I2C_LAST_CNT) begin
					if (first_reg) begin
						match_reg <= sh_reg[6:0] == OWN_ADDR;
						rw_reg <= bus.sda;
					end else if (match_reg && !rw_reg) begin
						i2c_rx_valid <= 1'b1;
						i2c_rx_data <= rx_byte;
						i2c_por <= rx_byte == POR_CMD;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Two-wire drive on falling clock
	// ----------------------------------------------------------------
	always_ff @(negedge bus.scl or posedge reset) begin
		if (reset) begin
			oe_reg <= 1'b0;
			txs_reg <= FILL_BYTE;
		end else if (start_pend) begin
			oe_reg <= 1'b0;
		end else if (cnt_reg == ACK_SLOT) begin
			// Acknowledge whatever the address, except data slots of a read of own address
			oe_reg <= !own_rd;
		end else if (own_rd && !halt_reg && cnt_reg == 4'h0) begin
			txs_reg <= tx_data;
			oe_reg <= !tx_data[7];
		end else if (own_rd && !halt_reg && cnt_reg < ACK_SLOT) begin
			oe_reg <= !txs_reg[3'h7 - cnt_reg[2:0]];
		end else begin
			// Released: master reads ones from the pull-up
			oe_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Four-wire shift in on rising clock
	// ----------------------------------------------------------------
	always_ff @(posedge bus.sclk or posedge reset) begin
		if (reset) begin
			scnt_reg <= 3'h0;
			ssh_reg <= '0;
			spi_rx_valid <= 1'b0;
			spi_rx_data <= '0;
			spi_por <= 1'b0;
		end else begin
			spi_rx_valid <= 1'b0;
			spi_por <= 1'b0;
			if (!bus.slave_select_n) begin
				ssh_reg <= srx_byte;
				scnt_reg <= scnt_reg + 3'h1;
				if (scnt_reg == SPI_CNT_LAST) begin
					spi_rx_valid <= 1'b1;
					spi_rx_data <= srx_byte;
					spi_por <= srx_byte == POR_CMD;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Four-wire shift out on falling clock
	// ----------------------------------------------------------------
	always_ff @(negedge bus.sclk or posedge reset) begin
		if (reset) begin
			stx_reg <= FILL_BYTE;
			miso_reg <= 1'b1;
		end else if (scnt_reg == 3'h0) begin
			stx_reg <= tx_data;
			miso_reg <= tx_data[7];
		end else begin
			miso_reg <= stx_reg[3'h7 - scnt_reg];
		end
	end
endmodule // ssbq_device

`default_nettype wire

// ==== tb/ssbq_checker.sv ====
// Link-level checker for the serial slave link
`timescale 1ns/10ps
`default_nettype none

module ssbq_checker
	import ssbq_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe,
	input wire logic sclk,
	input wire logic slave_select_n,
	input wire logic mosi,
	input wire logic miso
);
	logic scl_reg, sda_reg, halt_reg;
	logic [7:0] slot_reg;
	logic [7:0] addr_reg;
	logic scl_rise, start_seen, ack_slot, own_read;

	// ------------------------------------------------------------
	// Slot tracking
	// ------------------------------------------------------------
	assign scl_rise = scl && !scl_reg;
	assign start_seen = scl && scl_reg && sda_reg && !sda;
	assign ack_slot = scl_rise && (slot_reg % 8'h09 == 8'h08);
	assign own_read = addr_reg == {DEV_ADDR, 1'b1} && slot_reg > 8'h08;

	always_ff @(posedge clock) begin
		scl_reg <= scl;
		sda_reg <= sda;
	end
	always_ff @(posedge clock) begin
		if (reset || start_seen)
			slot_reg <= 8'h00;
		else if (scl_rise)
			slot_reg <= slot_reg + 8'h01;
	end
	always_ff @(posedge clock) begin
		if (scl_rise && slot_reg < 8'h08)
			addr_reg <= {addr_reg[6:0], sda};
	end
	// Master ack seen during own read
	always_ff @(posedge clock) begin
		if (reset || start_seen)
			halt_reg <= 1'b0;
		else if (ack_slot && own_read && !sda)
			halt_reg <= 1'b1;
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	addr_ack_a: assert property (scl_rise && slot_reg == 8'h08 |-> sda_dev_oe)
		else $error("address slot not acknowledged by device");
	data_ack_a: assert property (ack_slot && slot_reg != 8'h08 && !own_read |-> sda_dev_oe)
		else $error("data slot not acknowledged by device");
	halt_send_a: assert property (halt_reg |-> !sda_dev_oe)
		else $error("device drives after master acknowledge");
	oe_low_a: assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("device data changed while clock high");
	miso_hold_a: assert property (slave_select_n && $past(slave_select_n) |-> $stable(miso))
		else $error("data out moved while deselected");
	sclk_idle_a: assert property (slave_select_n |-> !sclk)
		else $error("serial clock active while deselected");
	mosi_hold_a: assert property (sclk |-> $stable(mosi))
		else $error("data in changed while clock high");
	reset_idle_a: assert property ($fell(reset) |-> scl && slave_select_n && !sclk && !sda_host_oe && !sda_dev_oe)
		else $error("link not idle after reset");

	cover property (ack_slot && own_read && !sda);
	cover property (start_seen);
	cover property ($fell(slave_select_n));
endmodule // ssbq_checker

`default_nettype wire

// ==== tb/ssbq_test.sv ====
// Self-checking bench joining both ends of the link
`timescale 1ns/10ps
`default_nettype none

module ssbq_test;
	import ssbq_pkg::*;
	logic clock, reset, wr_valid, wr_ready, cmd_valid, cmd_ready;
	logic cmd_spi, cmd_read, cmd_por, rd_valid, busy;
	logic i2c_rx_valid, i2c_por, spi_rx_valid, spi_por, i2c_v_q, spi_v_q;
	ssbq_byte_t wr_data, rd_data, tx_data, i2c_rx_data, spi_rx_data;
	ssbq_addr_t cmd_addr, a;
	ssbq_len_t cmd_len, len;
	ssbq_byte_t exp_q[$], dev_q[$], spi_q[$], rd_q[$];
	int fail_count = 0, samples_checked = 0, i2c_por_n, spi_por_n;

	ssbq_if bus_if();
	ssbq_host #(.QUARTER(4), .DEPTH(FIFO_DEPTH)) u_ssbq_host (.clock(clock),
		.reset(reset), .bus(bus_if), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_data(wr_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_spi(cmd_spi), .cmd_read(cmd_read), .cmd_por(cmd_por),
		.cmd_addr(cmd_addr), .cmd_len(cmd_len), .rd_valid(rd_valid),
		.rd_data(rd_data), .busy(busy));
	ssbq_device #(.OWN_ADDR(DEV_ADDR)) u_ssbq_device (.reset(reset),
		.bus(bus_if), .tx_data(tx_data), .i2c_rx_valid(i2c_rx_valid),
		.i2c_rx_data(i2c_rx_data), .i2c_por(i2c_por),
		.spi_rx_valid(spi_rx_valid), .spi_rx_data(spi_rx_data),
		.spi_por(spi_por));
	ssbq_checker u_ssbq_checker (.clock(clock), .reset(reset),
		.scl(bus_if.scl), .sda(bus_if.sda), .sda_host_oe(bus_if.sda_host_oe),
		.sda_dev_oe(bus_if.sda_dev_oe), .sclk(bus_if.sclk),
		.slave_select_n(bus_if.slave_select_n), .mosi(bus_if.mosi),
		.miso(bus_if.miso));

	always #(CLK_NS / 2) clock = ~clock;

	// ------------------------------------------------------------
	// Monitors
	// ------------------------------------------------------------
	always @(posedge clock) begin
		i2c_v_q <= i2c_rx_valid;
		spi_v_q <= spi_rx_valid;
		if (i2c_rx_valid === 1'b1 && i2c_v_q === 1'b0) begin
			dev_q.push_back(i2c_rx_data);
			if (i2c_por === 1'b1) i2c_por_n++;
		end
		if (spi_rx_valid === 1'b1 && spi_v_q === 1'b0) begin
			spi_q.push_back(spi_rx_data);
			if (spi_por === 1'b1) spi_por_n++;
		end
		if (rd_valid === 1'b1) rd_q.push_back(rd_data);
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	function automatic ssbq_byte_t read_exp(input ssbq_byte_t tx, input int idx);
		return (idx == 0) ? tx : FILL_BYTE;
	endfunction

	task automatic check_byte(input ssbq_byte_t e, input ssbq_byte_t g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic check_count(input int e, input int g);
		samples_checked++;
		if (g != e) begin
			fail_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic cmp_q(input ssbq_byte_t e[$], input ssbq_byte_t g[$]);
		check_count(e.size(), g.size());
		for (int i = 0; i < e.size() && i < g.size(); i++) check_byte(e[i], g[i]);
	endtask

	task automatic fill(input int n);
		ssbq_byte_t b;
		exp_q = {};
		@(posedge clock);
		for (int i = 0; i < n; i++) begin
			b = ssbq_byte_t'($urandom);
			exp_q.push_back(b);
			wr_data <= b;
			wr_valid <= 1'b1;
			@(posedge clock);
			while (wr_ready !== 1'b1) @(posedge clock);
		end
		wr_valid <= 1'b0;
	endtask

	task automatic run_cmd(input logic s, input logic r, input logic p,
		input ssbq_addr_t ad, input ssbq_len_t ln);
		int n;
		dev_q = {};
		spi_q = {};
		rd_q = {};
		i2c_por_n = 0;
		spi_por_n = 0;
		@(posedge clock);
		{cmd_spi, cmd_read, cmd_por} <= {s, r, p};
		cmd_addr <= ad;
		cmd_len <= ln;
		cmd_valid <= 1'b1;
		@(posedge clock);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (busy !== 1'b0 && n < 20000);
		check_byte(8'h00, {7'h00, busy});
		check_byte(8'h01, {7'h00, cmd_ready});
		repeat (4) @(posedge clock);
	endtask

	task automatic final_report();
		$display("checked=%0d failed=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#(CLK_NS * 50000);
		fail_count++;
		$display("watchdog expired");
		final_report();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		{wr_valid, cmd_valid, cmd_spi, cmd_read, cmd_por} = 5'h00;
		{wr_data, tx_data, cmd_addr, cmd_len} = 27'h0;
		void'($urandom(32'hB147B0CE));
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		fill(8);
		@(posedge clock);
		#1;
		check_byte(8'h00, {7'h00, wr_ready});
		run_cmd(1'b0, 1'b0, 1'b0, DEV_ADDR, 4'h8);
		cmp_q(exp_q, dev_q);
		$display("test own_write done");
		for (int k = 0; k < 3; k++) begin
			a = ssbq_addr_t'($urandom);
			if (a == DEV_ADDR) a = a ^ 7'h01;
			len = ssbq_len_t'($urandom_range(4, 1));
			fill(int'(len));
			run_cmd(1'b0, 1'b0, 1'b0, a, len);
			check_count(0, dev_q.size());
		end
		$display("test foreign_write done");
		@(posedge clock);
		tx_data <= ssbq_byte_t'($urandom);
		run_cmd(1'b0, 1'b1, 1'b0, DEV_ADDR, 4'h3);
		exp_q = {};
		for (int i = 0; i < 3; i++) exp_q.push_back(read_exp(tx_data, i));
		cmp_q(exp_q, rd_q);
		$display("test own_read done");
		run_cmd(1'b0, 1'b1, 1'b0, DEV_ADDR ^ 7'h10, 4'h2);
		cmp_q({FILL_BYTE, FILL_BYTE}, rd_q);
		check_count(0, dev_q.size());
		$display("test foreign_read done");
		run_cmd(1'b0, 1'b0, 1'b1, DEV_ADDR, LEN_ONE);
		check_count(1, i2c_por_n);
		run_cmd(1'b1, 1'b0, 1'b1, DEV_ADDR, LEN_ONE);
		check_count(1, spi_por_n);
		$display("test power_up_reset done");
		len = ssbq_len_t'($urandom_range(4, 1));
		fill(int'(len));
		run_cmd(1'b1, 1'b0, 1'b0, DEV_ADDR, len);
		cmp_q(exp_q, spi_q);
		$display("test spi_write done");
		fill(2);
		run_cmd(1'b1, 1'b1, 1'b0, DEV_ADDR, 4'h2);
		cmp_q({tx_data, tx_data}, rd_q);
		$display("test spi_read done");
		final_report();
	end
endmodule // ssbq_test

`default_nettype wire
